//--- pcap_pkg.sv
// Overview of operation
// - Set register ones enable mask bits
// - Clear register ones disable mask bits
// - Mask register reads enabled sources
// - Bits: ready 0, overrun 1, end 2, full 3
// - Ready flag rises on new captured word
// - Ready clears on disable, or on holding read with no word buffered
// - Overrun flag rises on lost word
// - Overrun clears on status read or disable
// - Transfer-end bit mirrors DMA end signal
// - Buffer-full bit mirrors DMA full signal
// - Byte width keeps low 8 bits
// - Half-word width keeps low 16 bits
// - Capture on bit enables capture
// - Width codes: 0 byte, 1 half, 2 word
// - Half-rate keeps every other sample, parity selectable
package pcap_pkg;

    localparam logic [31:0] PCAP_MODE_ADDR = 32'h400E0F50;
    localparam logic [31:0] PCAP_SET_ADDR = 32'h400E0F54;
    localparam logic [31:0] PCAP_CLR_ADDR = 32'h400E0F58;
    localparam logic [31:0] PCAP_MASK_ADDR = 32'h400E0F5C;
    localparam logic [31:0] PCAP_FLAGS_ADDR = 32'h400E0F60;
    localparam logic [31:0] PCAP_HOLD_ADDR = 32'h400E0F64;

    localparam int PCAP_NSRC = 4;
    localparam int PCAP_BIT_READY = 0;
    localparam int PCAP_BIT_OVR = 1;
    localparam int PCAP_BIT_END = 2;
    localparam int PCAP_BIT_FULL = 3;

    localparam int PCAP_MODE_ON_BIT = 0;
    localparam int PCAP_MODE_WIDTH_LSB = 4;
    localparam int PCAP_MODE_HALF_BIT = 10;
    localparam int PCAP_MODE_ODD_BIT = 11;

    localparam logic [3:0] PCAP_MASK_RST = 4'h0;
    localparam logic [31:0] PCAP_WORD_RST = 32'h0000_0000;
    localparam logic [31:0] PCAP_BYTE_KEEP = 32'h0000_00FF;
    localparam logic [31:0] PCAP_HALF_KEEP = 32'h0000_FFFF;
    localparam logic [1:0] PCAP_BUF_DEPTH = 2'h2;

    typedef enum logic [1:0] {
        PCAP_W_BYTE = 2'h0,
        PCAP_W_HALF = 2'h1,
        PCAP_W_WORD = 2'h2,
        PCAP_W_RSVD = 2'h3
    } pcap_width_t;

    typedef struct packed {
        logic odd_sample_select;
        logic half_rate_sampling;
        pcap_width_t capture_width;
        logic capture_on;
    } pcap_mode_t;

    localparam pcap_mode_t PCAP_MODE_RST = '{1'b0, 1'b0, PCAP_W_BYTE, 1'b0};

    typedef struct packed {
        logic valid;
        logic [31:0] data;
    } pcap_word_t;

endpackage

//--- pcap_decim.sv
`timescale 1ns/1ps
`default_nettype none
module pcap_decim
    import pcap_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_ce,
    input wire logic i_on,
    input wire logic i_half,
    input wire logic i_odd,
    input wire pcap_word_t i_word,
    output pcap_word_t o_word
);
    typedef struct packed {
        logic odd_next;
        pcap_word_t out;
    } pcap_dec_st_t;

    pcap_dec_st_t st_q;
    pcap_dec_st_t st_d;

    always_comb begin
        st_d = st_q;
        st_d.out.valid = 1'b0;
        if (!i_on) begin
            // Index restarts at zero for each capture session
            st_d.odd_next = 1'b0;
        end else if (i_word.valid) begin
            st_d.odd_next = !st_q.odd_next;
            if (!i_half || (st_q.odd_next == i_odd)) begin
                st_d.out.valid = 1'b1;
                st_d.out.data = i_word.data;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            st_q <= '{1'b0, '{1'b0, PCAP_WORD_RST}};
        end else if (i_ce) begin
            st_q <= st_d;
        end
    end

    assign o_word = st_q.out;
endmodule
`default_nettype wire

//--- pcap_buf.sv
`timescale 1ns/1ps
`default_nettype none
module pcap_buf
    import pcap_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_ce,
    input wire logic i_flush,
    input wire pcap_word_t i_in,
    output logic o_in_ready,
    output pcap_word_t o_out,
    input wire logic i_out_ready
);
    typedef struct packed {
        logic [1:0][31:0] mem;
        logic wp;
        logic rp;
        logic [1:0] cnt;
        logic room;
        logic avail;
    } pcap_buf_st_t;

    pcap_buf_st_t st_q;
    pcap_buf_st_t st_d;
    logic push;
    logic pop;

    always_comb begin
        st_d = st_q;
        push = i_in.valid && st_q.room;
        pop = st_q.avail && i_out_ready;
        if (i_flush) begin
            st_d.wp = 1'b0;
            st_d.rp = 1'b0;
            st_d.cnt = 2'h0;
        end else begin
            if (push) begin
                st_d.mem[st_q.wp] = i_in.data;
                st_d.wp = !st_q.wp;
            end
            if (pop) begin
                st_d.rp = !st_q.rp;
            end
            st_d.cnt = st_q.cnt + {1'b0, push} - {1'b0, pop};
        end
        // Flags kept as flops so the upstream ready is glitch free
        st_d.room = (st_d.cnt != PCAP_BUF_DEPTH);
        st_d.avail = (st_d.cnt != 2'h0);
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            st_q <= '{'0, 1'b0, 1'b0, 2'h0, 1'b1, 1'b0};
        end else if (i_ce) begin
            st_q <= st_d;
        end
    end

    assign o_in_ready = st_q.room;
    assign o_out = '{st_q.avail, st_q.mem[st_q.rp]};
endmodule
`default_nettype wire

//--- pcap_top.sv
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module pcap_top
    import pcap_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_SRST,
    input wire logic I_CE,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [31:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    input wire logic I_CAP_VALID,
    input wire logic [31:0] I_CAP_DATA,
    output logic O_CAP_READY,
    input wire logic I_RX_END,
    input wire logic I_RX_FULL,
    output logic O_DATA_READY,
    output logic O_IRQ
);
    typedef struct packed {
        pcap_mode_t mode;
        logic [PCAP_NSRC-1:0] mask;
        logic data_ready;
        logic overrun;
        logic [31:0] hold;
        logic [31:0] rdata;
        logic pready;
        logic slverr;
        logic irq;
    } pcap_top_st_t;

    pcap_top_st_t st_q;
    pcap_top_st_t st_d;

    pcap_word_t cap_in;
    pcap_word_t dec_out;
    pcap_word_t buf_out;
    logic buf_in_ready;
    logic buf_pop;
    logic access;
    logic rd_hold;
    logic rd_flags;
    logic lost;
    logic [PCAP_NSRC-1:0] flags_now;
    logic [PCAP_NSRC-1:0] flags_next;
    logic [31:0] keep;

    assign cap_in = '{I_CAP_VALID && st_q.mode.capture_on, I_CAP_DATA};

    pcap_decim u_decim (
        .i_clk(I_CLK),
        .i_srst(I_SRST),
        .i_ce(I_CE),
        .i_on(st_q.mode.capture_on),
        .i_half(st_q.mode.half_rate_sampling),
        .i_odd(st_q.mode.odd_sample_select),
        .i_word(cap_in),
        .o_word(dec_out)
    );

    // Two words of slack absorb a slow holding-register read
    pcap_buf u_buf (
        .i_clk(I_CLK),
        .i_srst(I_SRST),
        .i_ce(I_CE),
        .i_flush(!st_q.mode.capture_on),
        .i_in(dec_out),
        .o_in_ready(buf_in_ready),
        .o_out(buf_out),
        .i_out_ready(buf_pop)
    );

    always_comb begin
        st_d = st_q;
        st_d.pready = 1'b0;
        st_d.slverr = 1'b0;
        // Side effects act on the first access edge, when read data is latched
        access = I_PSEL && I_PENABLE && !st_q.pready;
        rd_hold = access && !I_PWRITE && (I_PADDR == PCAP_HOLD_ADDR);
        rd_flags = access && !I_PWRITE && (I_PADDR == PCAP_FLAGS_ADDR);

        flags_now = '0;
        flags_now[PCAP_BIT_READY] = st_q.data_ready;
        flags_now[PCAP_BIT_OVR] = st_q.overrun;
        flags_now[PCAP_BIT_END] = I_RX_END;
        flags_now[PCAP_BIT_FULL] = I_RX_FULL;

        if (access) begin
            st_d.pready = 1'b1;
            st_d.rdata = PCAP_WORD_RST;
            unique case (I_PADDR)
                PCAP_MODE_ADDR: begin
                    if (I_PWRITE) begin
                        st_d.mode.capture_on = I_PWDATA[PCAP_MODE_ON_BIT];
                        st_d.mode.capture_width =
                            pcap_width_t'(I_PWDATA[PCAP_MODE_WIDTH_LSB +: 2]);
                        st_d.mode.half_rate_sampling = I_PWDATA[PCAP_MODE_HALF_BIT];
                        st_d.mode.odd_sample_select = I_PWDATA[PCAP_MODE_ODD_BIT];
                    end else begin
                        st_d.rdata[PCAP_MODE_ON_BIT] = st_q.mode.capture_on;
                        st_d.rdata[PCAP_MODE_WIDTH_LSB +: 2] = st_q.mode.capture_width;
                        st_d.rdata[PCAP_MODE_HALF_BIT] = st_q.mode.half_rate_sampling;
                        st_d.rdata[PCAP_MODE_ODD_BIT] = st_q.mode.odd_sample_select;
                    end
                end
                PCAP_SET_ADDR: begin
                    if (I_PWRITE) begin
                        st_d.mask = st_q.mask | I_PWDATA[PCAP_NSRC-1:0];
                    end
                end
                PCAP_CLR_ADDR: begin
                    if (I_PWRITE) begin
                        st_d.mask = st_q.mask & ~I_PWDATA[PCAP_NSRC-1:0];
                    end
                end
                PCAP_MASK_ADDR: begin
                    st_d.rdata[PCAP_NSRC-1:0] = st_q.mask;
                end
                PCAP_FLAGS_ADDR: begin
                    st_d.rdata[PCAP_NSRC-1:0] = flags_now;
                end
                PCAP_HOLD_ADDR: begin
                    st_d.rdata = st_q.hold;
                end
                default: begin
                    st_d.slverr = 1'b1;
                end
            endcase
        end
        unique case (st_q.mode.capture_width)
            PCAP_W_BYTE: keep = PCAP_BYTE_KEEP;
            PCAP_W_HALF: keep = PCAP_HALF_KEEP;
            default: keep = ~PCAP_WORD_RST; // Reserved code treated as full word
        endcase

        // Refill only when the previous word was consumed, never overwrite
        buf_pop = buf_out.valid && st_q.mode.capture_on && (!st_q.data_ready || rd_hold);
        if (buf_pop) begin
            st_d.hold = buf_out.data & keep;
            st_d.data_ready = 1'b1;
        end else if (rd_hold) begin
            st_d.data_ready = 1'b0;
        end

        // A word is lost only when both buffer entries are taken
        lost = dec_out.valid && !buf_in_ready;
        if (lost) begin
            st_d.overrun = 1'b1;
        end else if (rd_flags) begin
            st_d.overrun = 1'b0;
        end

        // Next mode, so the disabling write clears flags on its own edge
        if (!st_d.mode.capture_on) begin
            st_d.data_ready = 1'b0;
            st_d.overrun = 1'b0;
        end

        flags_next = flags_now;
        flags_next[PCAP_BIT_READY] = st_d.data_ready;
        flags_next[PCAP_BIT_OVR] = st_d.overrun;
        st_d.irq = |(flags_next & st_d.mask);
    end

    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            st_q <= '{PCAP_MODE_RST, PCAP_MASK_RST, 1'b0, 1'b0, PCAP_WORD_RST,
                      PCAP_WORD_RST, 1'b0, 1'b0, 1'b0};
        end else if (I_CE) begin
            st_q <= st_d;
        end
    end

    assign O_PRDATA = st_q.rdata;
    assign O_PREADY = st_q.pready;
    assign O_PSLVERR = st_q.slverr;
    assign O_CAP_READY = buf_in_ready;
    assign O_DATA_READY = st_q.data_ready;
    assign O_IRQ = st_q.irq;
endmodule
`default_nettype wire

//--- pcap_properties.sv
`timescale 1ns/1ps
`default_nettype none
module pcap_props
    import pcap_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_SRST,
    input wire logic I_CE,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [31:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic [31:0] O_PRDATA,
    input wire logic O_PREADY,
    input wire logic O_PSLVERR,
    input wire logic I_CAP_VALID,
    input wire logic [31:0] I_CAP_DATA,
    input wire logic O_CAP_READY,
    input wire logic I_RX_END,
    input wire logic I_RX_FULL,
    input wire logic O_DATA_READY,
    input wire logic O_IRQ
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_SRST);
    wire logic take = I_PSEL && I_PENABLE && !O_PREADY;
    wire logic clears = !I_PWRITE && I_PADDR == PCAP_HOLD_ADDR || I_PWRITE && I_PADDR == PCAP_MODE_ADDR;
    wire logic flags_rd = !I_PWRITE && I_PADDR == PCAP_FLAGS_ADDR;
    wire logic wo_rd = !I_PWRITE && I_PADDR inside {PCAP_SET_ADDR, PCAP_CLR_ADDR};
    wire logic mapped = I_PADDR inside {PCAP_MODE_ADDR, PCAP_SET_ADDR, PCAP_CLR_ADDR,
        PCAP_MASK_ADDR, PCAP_FLAGS_ADDR, PCAP_HOLD_ADDR};
    sequence s_take;
        take;
    endsequence
    sequence s_pulse;
        O_PREADY ##1 !O_PREADY;
    endsequence
    a_ready_pulse: assert property (s_take |=> s_pulse)
        else $error("ready pulse missing");
    a_err_unmapped: assert property (s_take ##0 !mapped |=> O_PSLVERR && O_PREADY)
        else $error("unmapped access not refused");
    a_err_cause: assert property (O_PSLVERR |-> $past(take) && !$past(mapped))
        else $error("spurious error response");
    a_wo_zero: assert property (O_PREADY && wo_rd |-> O_PRDATA == 32'h0)
        else $error("write-only register read nonzero");
    a_flag_mirror: assert property (O_PREADY && flags_rd |->
        O_PRDATA[31:2] == {28'h0, $past(I_RX_FULL), $past(I_RX_END)})
        else $error("flag bits wrong");
    a_ready_delay: assert property ($rose(O_DATA_READY) |-> $past(I_CAP_VALID, 3))
        else $error("data ready without sample");
    a_ready_holds: assert property (O_DATA_READY && !(take && clears) |=> O_DATA_READY)
        else $error("data ready dropped");
    a_reset_quiet: assert property ($fell(I_SRST) |-> !O_IRQ && !O_DATA_READY && O_CAP_READY)
        else $error("outputs wrong after reset");
    a_rdata_holds: assert property (!$past(take) |-> $stable(O_PRDATA))
        else $error("read data moved");
endmodule
bind pcap_top pcap_props u_props (.I_CLK, .I_SRST, .I_CE, .I_PSEL, .I_PENABLE, .I_PWRITE,
    .I_PADDR, .I_PWDATA, .O_PRDATA, .O_PREADY, .O_PSLVERR, .I_CAP_VALID, .I_CAP_DATA,
    .O_CAP_READY, .I_RX_END, .I_RX_FULL, .O_DATA_READY, .O_IRQ);
`default_nettype wire

//--- pcap_src.sv
`timescale 1ns/1ps
`default_nettype none
module pcap_src (
    input wire logic i_clk,
    input wire logic i_send,
    input wire logic [31:0] i_word,
    output logic o_valid,
    output logic [31:0] o_data
);
    initial o_valid = 1'b0;
    initial o_data = 32'h5A5A_A5A5;
    // Outside a sample the bus inverts each cycle, so the stale word returns every other cycle
    always @(posedge i_clk) begin
        o_valid <= i_send;
        o_data <= i_send ? i_word : ~o_data;
    end
endmodule
`default_nettype wire

//--- tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] %0t got %h want %h", $time, g, e); end end
module tb;
    import pcap_pkg::*;
    typedef struct packed {logic w; logic [31:0] a; logic [31:0] v; logic x;} pcap_row_t;
    logic clk = 1'b0, srst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, send = 1'b0, ce = 1'b1;
    logic rx_end = 1'b0, rx_full = 1'b0, cv, err, pready, pslverr, cap_ready, capture_data_ready, irq;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, word = 32'h0, cd, rd, prdata;
    logic [31:0] keep [4] = '{32'hFF, 32'hFFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF};
    int bad_count = 0, samples_checked = 0, cyc = 0;
    localparam logic [31:0] BAD = 32'h400E_0F68;
    pcap_row_t rows [15] = '{'{1'b0, PCAP_MASK_ADDR, 32'h0, 1'b0}, '{1'b0, PCAP_HOLD_ADDR, 32'h0, 1'b0},
        '{1'b0, PCAP_SET_ADDR, 32'h0, 1'b0}, '{1'b0, PCAP_CLR_ADDR, 32'h0, 1'b0},
        '{1'b1, PCAP_SET_ADDR, 32'hF, 1'b0}, '{1'b0, PCAP_MASK_ADDR, 32'hF, 1'b0},
        '{1'b1, PCAP_CLR_ADDR, 32'h5, 1'b0}, '{1'b1, PCAP_CLR_ADDR, 32'h0, 1'b0},
        '{1'b1, PCAP_SET_ADDR, 32'h0, 1'b0}, '{1'b1, PCAP_MASK_ADDR, 32'hF, 1'b0},
        '{1'b0, PCAP_MASK_ADDR, 32'hA, 1'b0}, '{1'b0, BAD, 32'h0, 1'b1}, '{1'b1, BAD, 32'hF, 1'b1},
        '{1'b1, PCAP_CLR_ADDR, 32'hF, 1'b0}, '{1'b0, PCAP_MASK_ADDR, 32'h0, 1'b0}};
    always #5 clk = ~clk;
    pcap_top DUT (.I_CLK(clk), .I_SRST(srst), .I_CE(ce), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .I_CAP_VALID(cv), .I_CAP_DATA(cd), .O_CAP_READY(cap_ready),
        .I_RX_END(rx_end), .I_RX_FULL(rx_full), .O_DATA_READY(capture_data_ready), .O_IRQ(irq));
    pcap_src SRC (.i_clk(clk), .i_send(send), .i_word(word), .o_valid(cv), .o_data(cd));
    task automatic finish_test();
        if (bad_count == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic put(input logic [31:0] d);
        @(posedge clk);
        send <= 1'b1;
        word <= d;
        @(posedge clk);
        send <= 1'b0;
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        while (capture_data_ready !== 1'b1 && n < 12) begin
            @(posedge clk);
            n++;
        end
        `CHK(capture_data_ready, 1'b1)
    endtask
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            finish_test();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].v);
            `CHK(err, rows[i].x)
            if (!rows[i].w) `CHK(rd, rows[i].v)
        end
        apb(1'b1, PCAP_SET_ADDR, 32'hD);
        for (int i = 0; i < 4; i++) begin
            {rx_full, rx_end} <= 2'(i);
            apb(1'b0, PCAP_FLAGS_ADDR, 32'h0);
            `CHK(rd, 32'(i) << 2)
            `CHK(irq, i != 0)
        end
        {rx_full, rx_end} <= 2'h0;
        for (int w = 0; w < 4; w++) begin
            apb(1'b1, PCAP_MODE_ADDR, 32'(w << 4) | 32'h1);
            put(32'hA5C3_9E17);
            wait_ready();
            `CHK(irq, 1'b1)
            apb(1'b0, PCAP_HOLD_ADDR, 32'h0);
            `CHK(rd, 32'hA5C3_9E17 & keep[w])
            `CHK(capture_data_ready, 1'b0)
        end
        // Nobody drains, so the fourth word must be lost
        for (int i = 0; i < 4; i++) put(32'h1000 + 32'(i));
        repeat (4) @(posedge clk);
        `CHK(cap_ready, 1'b0)
        apb(1'b0, PCAP_FLAGS_ADDR, 32'h0);
        `CHK(rd, 32'h3)
        apb(1'b0, PCAP_FLAGS_ADDR, 32'h0);
        `CHK(rd, 32'h1)
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, PCAP_HOLD_ADDR, 32'h0);
            `CHK(rd, 32'h1000 + 32'(i))
        end
        `CHK(capture_data_ready, 1'b0)
        put(32'h77);
        put(32'h78);
        put(32'h79);
        put(32'h7A);
        wait_ready();
        apb(1'b1, PCAP_MODE_ADDR, 32'h0);
        `CHK(capture_data_ready, 1'b0)
        apb(1'b0, PCAP_FLAGS_ADDR, 32'h0);
        `CHK(rd, 32'h0)
        put(32'h55);
        repeat (6) @(posedge clk);
        `CHK(capture_data_ready, 1'b0)
        for (int o = 0; o < 2; o++) begin
            apb(1'b1, PCAP_MODE_ADDR, 32'h0);
            apb(1'b1, PCAP_MODE_ADDR, 32'h421 | 32'(o << 11));
            put(32'hB0);
            put(32'hB1);
            wait_ready();
            apb(1'b0, PCAP_HOLD_ADDR, 32'h0);
            `CHK(rd, 32'hB0 + 32'(o))
            repeat (4) @(posedge clk);
            `CHK(capture_data_ready, 1'b0)
        end
        apb(1'b1, PCAP_MODE_ADDR, 32'h21);
        put(32'h99);
        wait_ready();
        // Frozen clock enable must ignore a sample
        ce <= 1'b0;
        put(32'h9A);
        repeat (2) @(posedge clk);
        ce <= 1'b1;
        apb(1'b0, PCAP_HOLD_ADDR, 32'h0);
        `CHK(rd, 32'h99)
        `CHK(capture_data_ready, 1'b0)
        put(32'h9B);
        wait_ready();
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        `CHK(irq, 1'b0)
        apb(1'b0, PCAP_MASK_ADDR, 32'h0);
        `CHK(rd, 32'h0)
        finish_test();
    end
endmodule
`default_nettype wire
